// file: inc/cmdexc_pkg.sv
// constants, carriers and state codes for the command and exception unit
package cmdexc_pkg;
  // register indices on the plain register port
  localparam logic [3:0] REG_CMD = 4'h0; // host_command_word
  localparam logic [3:0] REG_FLAGS = 4'h1; // global_flag_word, write one to clear
  localparam logic [3:0] REG_FMASK = 4'h2; // global_flag_mask
  localparam logic [3:0] REG_CHMASK = 4'h3; // channel_irq_mask
  localparam logic [3:0] REG_QBASE = 4'h4; // irq_queue_base
  localparam logic [3:0] REG_QPTR = 4'h5; // irq_queue_write_ptr
  localparam logic [3:0] REG_GMODE = 4'h6; // general_mode_word
  localparam logic [3:0] REG_CHSEL = 4'h7; // channel index for the two below
  localparam logic [3:0] REG_CHMODE = 4'h8; // channel_mode_word of selected channel
  localparam logic [3:0] REG_RXST = 4'h9; // rx_internal_state of selected channel
  // host_command_word fields
  localparam int CMD_RST_BIT = 0;
  localparam int CMD_OP_LSB = 1;
  localparam int CMD_CH_LSB = 8;
  localparam int CMD_PEND_BIT = 15;
  localparam logic [2:0] OP_STOP_RX = 3'h0;
  localparam logic [2:0] OP_STOP_TX = 3'h1;
  // global_flag_word and global_flag_mask bits
  localparam int FLG_OVR = 0; // global_rx_overrun
  localparam int FLG_UND = 1; // global_tx_underrun
  localparam int FLG_QNEW = 2; // queue_new_item_flag
  localparam int FLG_QOVF = 3; // queue overflow
  localparam int FLG_W = 4;
  // general_mode_word bits
  localparam int GM_TXEN = 0;
  localparam int GM_RXEN = 1;
  // rx_internal_state stopped bit
  localparam int RXST_STOP_BIT = 20;
  // fill bytes
  localparam logic [7:0] BYTE_ABORT = 8'h7f;
  localparam logic [7:0] BYTE_FLAG = 8'h7e;
  localparam logic [7:0] BYTE_IDLE = 8'hff;
  // abort sequencer codes per channel
  localparam logic [1:0] ABT_NONE = 2'h0; // nothing pending
  localparam logic [1:0] ABT_7F = 2'h1; // one abort byte pending
  localparam logic [1:0] ABT_ONES_LAST = 2'h2; // second all-ones byte pending
  localparam logic [1:0] ABT_ONES = 2'h3; // two all-ones bytes pending
  // reset values
  localparam logic [15:0] QADDR_RST = 16'h0000;
  localparam logic [7:0] CHMASK_RST = 8'h00;
  localparam logic [FLG_W-1:0] FMASK_RST = 4'h0;
  localparam logic [1:0] GMODE_RST = 2'h0;
  // interrupt queue item as written to external memory
  typedef struct packed {
    logic valid; // item holds an unserved exception
    logic wrap; // last item of the circular queue
    logic [5:0] chan; // logical channel number
    logic [7:0] code; // exception description
  } qitem_type;
  // channel_mode_word as seen on the register port
  typedef struct packed {
    logic ena; // channel_enable_bit
    logic idle_sel; // idle_fill_select: 1 flags, 0 idles
    logic go; // transmit_go_bit
  } chmode_type;
  // queue writer states
  typedef enum logic [3:0] {
    Q_IDLE = 4'h1,
    Q_READ = 4'h2,
    Q_CHECK = 4'h4,
    Q_FLAG = 4'h8
  } qstate_type;
endpackage

// file: verif/cmd_exception_unit_props.sv
// concurrent checks bound onto the command and exception unit ports
`timescale 1ns/1ps
`default_nettype none
module cmd_exception_unit_props #(
  parameter int NCH = 32, // logical channels
  parameter int CW = 5 // channel index width
) (
  input wire logic CLK, // system clock
  input wire logic RST_N, // sync reset, low
  input wire logic RD, // read strobe
  input wire logic [31:0] RDATA, // read data
  input wire logic EXC_VALID, // exception request
  input wire logic EXC_READY, // writer idle
  input wire logic MEM_RD, // item read pulse
  input wire logic MEM_WR, // item write pulse
  input wire cmdexc_pkg::qitem_type MEM_WDATA, // item written
  input wire logic SLOT_STB, // slot due
  input wire logic [7:0] SLOT_DATA, // buffer byte
  input wire logic [7:0] TX_BYTE, // sent byte
  input wire logic TX_VLD, // sent byte new
  input wire logic TX_FETCH, // buffer byte consumed
  input wire logic [NCH-1:0] RX_CHAN_EN, // receivers enabled
  input wire logic GUN_EV, // global underrun
  input wire logic GOV_EV // global overrun
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // request accepted by the idle writer
  sequence taken;
    EXC_VALID && EXC_READY;
  endsequence
  // busy two cycles from the item read, then the write or a refused item frees it
  sequence busy_then_free;
    !EXC_READY [*2] ##1 (MEM_WR ^ EXC_READY) ##1 (EXC_READY || MEM_RD);
  endsequence
  // underrun followed at once by a slot
  sequence gun_then_slot;
    GUN_EV ##1 SLOT_STB;
  endsequence
  a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero outside the answer cycle");
  a_take_reads: assert property (taken |=> MEM_RD || EXC_READY)
    else $error("taken request neither read the queue nor was dropped");
  a_ready_gap: assert property (MEM_RD |-> busy_then_free)
    else $error("writer ready timing wrong around an item");
  a_write_after_read: assert property (MEM_WR |-> $past(MEM_RD, 2) && MEM_WDATA.valid && MEM_WDATA.code != 8'h00)
    else $error("item write without read, valid bit or unmasked code");
  a_slot_answer: assert property (SLOT_STB |=> TX_VLD)
    else $error("slot not answered next cycle");
  a_fetch_data: assert property (TX_FETCH |-> TX_VLD && TX_BYTE == $past(SLOT_DATA))
    else $error("fetched byte differs from buffer byte");
  a_ovr_stops_rx: assert property (GOV_EV |-> ##[1:2] RX_CHAN_EN == '0)
    else $error("receivers still enabled after overrun");
  a_gun_ones: assert property (gun_then_slot |=> TX_BYTE == 8'hff && !TX_FETCH)
    else $error("slot after underrun not all ones");
endmodule // cmd_exception_unit_props
bind cmd_exception_unit cmd_exception_unit_props #(.NCH(NCH), .CW(CW)) u_props (
  .CLK(CLK), .RST_N(RST_N), .RD(RD), .RDATA(RDATA), .EXC_VALID(EXC_VALID), .EXC_READY(EXC_READY),
  .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .SLOT_STB(SLOT_STB), .SLOT_DATA(SLOT_DATA),
  .TX_BYTE(TX_BYTE), .TX_VLD(TX_VLD), .TX_FETCH(TX_FETCH), .RX_CHAN_EN(RX_CHAN_EN), .GUN_EV(GUN_EV),
  .GOV_EV(GOV_EV)
);
`default_nettype wire

// file: verif/multichannel_cmd_exception_unit_test.sv
// self-checking bench for the command and exception unit
`timescale 1ns/1ps
`default_nettype none
module multichannel_cmd_exception_unit_test;
  logic clk = 1'b0; // 25 MHz clock
  logic rst_n = 1'b0; // sync reset, low
  logic [3:0] addr = 4'h0; // register index
  logic [31:0] wdata = 32'h0; // write data
  logic wr = 1'b0; // write strobe
  logic rd = 1'b0; // read strobe
  logic [31:0] rdata; // read answer
  logic exc_valid = 1'b0; // exception request
  logic [4:0] exc_chan = 5'h0; // requesting channel
  logic [7:0] exc_code = 8'h0; // exception description
  logic exc_ready, mem_rd, mem_wr; // writer handshakes
  logic [15:0] mem_addr; // item address
  cmdexc_pkg::qitem_type mem_wdata; // item written
  cmdexc_pkg::qitem_type mem_rdata = 16'h5a5a; // junk outside the read answer
  logic slot_stb = 1'b0; // slot due
  logic [4:0] slot_chan = 5'h0; // slot owner
  logic [7:0] slot_data = 8'h0; // buffer byte
  logic [31:0] in_frame = 32'h0; // channels mid-frame
  logic [7:0] tx_byte; // sent byte
  logic tx_vld, tx_fetch; // slot answer flags
  logic [31:0] rx_en; // receivers enabled
  logic gun_ev = 1'b0; // underrun pulse
  logic gov_ev = 1'b0; // overrun pulse
  logic irq; // host interrupt
  int error_cnt = 0; // mismatches
  int checks = 0; // comparisons
  // clock toggles every half period
  always #20 clk = ~clk;
  cmd_exception_unit #(.NCH(32), .CW(5)) DUT (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .EXC_VALID(exc_valid), .EXC_CHAN(exc_chan), .EXC_CODE(exc_code), .EXC_READY(exc_ready),
    .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
    .SLOT_STB(slot_stb), .SLOT_CHAN(slot_chan), .SLOT_DATA(slot_data), .TX_IN_FRAME(in_frame),
    .TX_BYTE(tx_byte), .TX_VLD(tx_vld), .TX_FETCH(tx_fetch), .RX_CHAN_EN(rx_en), .GUN_EV(gun_ev),
    .GOV_EV(gov_ev), .IRQ(irq)
  );
  // verdict and end of run, shared with the watchdog
  task automatic close_out;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // compare one value, four-state exact
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one write cycle; a gap cycle follows so strobes never double up
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one read cycle, answer looked at in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp(what, exp, rdata);
  endtask
  // command word with pending bit set
  task automatic cmd(input logic [2:0] op, input logic [4:0] ch, input logic rb);
    wr_reg(cmdexc_pkg::REG_CMD, {16'h0, 1'b1, 2'b0, ch, 4'h0, op, rb});
  endtask
  // channel mode write through the channel select
  task automatic chm(input logic [4:0] ch, input logic [31:0] v);
    wr_reg(cmdexc_pkg::REG_CHSEL, {27'h0, ch});
    wr_reg(cmdexc_pkg::REG_CHMODE, v);
  endtask
  // one slot and the byte that answers it
  task automatic slot(input logic [4:0] ch, input logic [7:0] d, input logic [7:0] exp, input logic f);
    @(posedge clk);
    slot_stb <= 1'b1;
    slot_chan <= ch;
    slot_data <= d;
    @(posedge clk);
    slot_stb <= 1'b0;
    slot_data <= ~d;
    @(negedge clk);
    cmp("tx_vld", 32'h1, {31'h0, tx_vld});
    cmp("tx_byte", {24'h0, exp}, {24'h0, tx_byte});
    cmp("tx_fetch", {31'h0, f}, {31'h0, tx_fetch});
  endtask
  // one exception through the queue writer, memory answered in place of the far side
  task automatic exc(input logic [4:0] ch, input logic [7:0] code, input logic [15:0] item, input logic rx,
                     input logic wx, input logic [15:0] ea, input logic [15:0] ei);
    int n;
    n = 0;
    @(posedge clk);
    exc_valid <= 1'b1;
    exc_chan <= ch;
    exc_code <= code;
    @(negedge clk);
    while (!exc_ready && n < 10) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    exc_valid <= 1'b0;
    exc_code <= ~code;
    @(negedge clk);
    cmp("mem_rd", {31'h0, rx}, {31'h0, mem_rd});
    if (rx) begin
      cmp("mem_addr", {16'h0, ea}, {16'h0, mem_addr});
      @(posedge clk);
      mem_rdata <= item;
      @(posedge clk);
      mem_rdata <= ~item;
      @(negedge clk);
      cmp("mem_wr", {31'h0, wx}, {31'h0, mem_wr});
      if (wx) cmp("mem_wdata", {16'h0, ei}, {16'h0, mem_wdata});
    end else cmp("exc_ready", 32'h1, {31'h0, exc_ready});
    repeat (3) @(posedge clk);
  endtask
  // reset values, readback and an unmapped index
  task automatic s_regs;
    logic [3:0] idx[7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hf};
    foreach (idx[i]) rchk(idx[i], 32'h0, "reset value");
    wr_reg(4'hf, 32'hffff_ffff);
    rchk(4'hf, 32'h0, "unmapped");
    wr_reg(cmdexc_pkg::REG_QBASE, 32'h0100);
    rchk(cmdexc_pkg::REG_QBASE, 32'h0100, "queue base");
  endtask
  // stop transmit mid-frame and between frames, ignored commands, restart
  task automatic s_tx;
    wr_reg(cmdexc_pkg::REG_GMODE, 32'h3);
    chm(5'd4, 32'h5);
    chm(5'd3, 32'h5);
    slot(5'd3, 8'ha5, 8'ha5, 1'b1);
    in_frame[3] <= 1'b1;
    cmd(cmdexc_pkg::OP_STOP_TX, 5'd3, 1'b0);
    rchk(cmdexc_pkg::REG_CHMODE, 32'h4, "go bit after stop");
    slot(5'd3, 8'h11, cmdexc_pkg::BYTE_ABORT, 1'b0);
    slot(5'd3, 8'h22, cmdexc_pkg::BYTE_IDLE, 1'b0);
    slot(5'd4, 8'h33, 8'h33, 1'b1);
    cmd(cmdexc_pkg::OP_STOP_TX, 5'd4, 1'b1);
    wr_reg(cmdexc_pkg::REG_CMD, 32'h0402);
    slot(5'd4, 8'h34, 8'h34, 1'b1);
    cmd(cmdexc_pkg::OP_STOP_TX, 5'd4, 1'b0);
    slot(5'd4, 8'h35, cmdexc_pkg::BYTE_IDLE, 1'b0);
    chm(5'd3, 32'h6);
    for (int op = 2; op < 8; op++) cmd(op[2:0], 5'd3, 1'b0);
    slot(5'd3, 8'h36, cmdexc_pkg::BYTE_FLAG, 1'b0);
    chm(5'd3, 32'h3);
    slot(5'd3, 8'h45, cmdexc_pkg::BYTE_FLAG, 1'b0);
    chm(5'd3, 32'h7);
    slot(5'd3, 8'h44, 8'h44, 1'b1);
  endtask
  // stop receive on one channel, neighbour untouched, host restart
  task automatic s_rx;
    chm(5'd5, 32'h4);
    chm(5'd2, 32'h4);
    cmd(cmdexc_pkg::OP_STOP_RX, 5'd2, 1'b0);
    repeat (2) @(posedge clk);
    cmp("rx_en ch2", 32'h0, {31'h0, rx_en[2]});
    cmp("rx_en ch5", 32'h1, {31'h0, rx_en[5]});
    rchk(cmdexc_pkg::REG_RXST, 32'h0010_0000, "stopped bit");
    rchk(cmdexc_pkg::REG_CHMODE, 32'h4, "mode kept");
    wr_reg(cmdexc_pkg::REG_RXST, 32'h0);
    repeat (2) @(posedge clk);
    cmp("rx_en restart", 32'h1, {31'h0, rx_en[2]});
  endtask
  // queue items, masking, wrap, overflow and write-one clearing
  task automatic s_queue;
    wr_reg(cmdexc_pkg::REG_QPTR, 32'h0100);
    wr_reg(cmdexc_pkg::REG_CHMASK, 32'h0f);
    exc(5'd7, 8'h33, 16'h0, 1'b1, 1'b1, 16'h0100, {2'b10, 6'd7, 8'h03});
    cmp("irq masked off", 32'h0, {31'h0, irq});
    wr_reg(cmdexc_pkg::REG_FMASK, 32'h4);
    rchk(cmdexc_pkg::REG_QPTR, 32'h0101, "pointer step");
    cmp("irq", 32'h1, {31'h0, irq});
    exc(5'd7, 8'hf0, 16'h0, 1'b0, 1'b0, 16'h0, 16'h0);
    exc(5'd9, 8'h01, 16'h4000, 1'b1, 1'b1, 16'h0101, {2'b11, 6'd9, 8'h01});
    rchk(cmdexc_pkg::REG_QPTR, 32'h0100, "pointer wrap");
    exc(5'd9, 8'h02, 16'h8000, 1'b1, 1'b0, 16'h0100, 16'h0);
    rchk(cmdexc_pkg::REG_QPTR, 32'h0100, "pointer on overflow");
    wr_reg(cmdexc_pkg::REG_FLAGS, 32'h0);
    rchk(cmdexc_pkg::REG_FLAGS, 32'hc, "flags kept");
    wr_reg(cmdexc_pkg::REG_FLAGS, 32'hf);
    rchk(cmdexc_pkg::REG_FLAGS, 32'h0, "flags cleared");
    cmp("irq cleared", 32'h0, {31'h0, irq});
  endtask
  // global underrun and overrun, then per-channel recovery
  task automatic s_global;
    wr_reg(cmdexc_pkg::REG_FMASK, 32'h3);
    chm(5'd3, 32'h5);
    @(posedge clk);
    gun_ev <= 1'b1;
    @(posedge clk);
    gun_ev <= 1'b0;
    slot_stb <= 1'b1;
    slot_chan <= 5'd3;
    slot_data <= 8'h55;
    @(posedge clk);
    slot_stb <= 1'b0;
    @(negedge clk);
    cmp("first ones", 32'hff, {24'h0, tx_byte});
    slot(5'd3, 8'h66, 8'hff, 1'b0);
    slot(5'd3, 8'h77, cmdexc_pkg::BYTE_IDLE, 1'b0);
    slot(5'd4, 8'h78, 8'hff, 1'b0);
    rchk(cmdexc_pkg::REG_FLAGS, 32'h2, "underrun flag");
    cmp("irq underrun", 32'h1, {31'h0, irq});
    chm(5'd3, 32'h5);
    slot(5'd3, 8'h88, 8'h88, 1'b1);
    @(posedge clk);
    gov_ev <= 1'b1;
    @(posedge clk);
    gov_ev <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("rx_en all", 32'h0, rx_en);
    wr_reg(cmdexc_pkg::REG_CHSEL, 32'h5);
    rchk(cmdexc_pkg::REG_RXST, 32'h0010_0000, "overrun stop");
    wr_reg(cmdexc_pkg::REG_RXST, 32'h0);
    rchk(cmdexc_pkg::REG_FLAGS, 32'h3, "global flags");
  endtask
  // reset for four cycles, then every scenario in turn
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    s_regs;
    s_tx;
    s_rx;
    s_queue;
    s_global;
    close_out;
  end
  // watchdog, far beyond the run's length
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    close_out;
  end
endmodule // multichannel_cmd_exception_unit_test
`default_nettype wire

// file: verilog/cmd_exception_unit.sv
// command decoder, interrupt queue writer and global error handling
//
// Contract
// - command word: reset, opcode, channel, pending bit 15
// - stop transmit clears channel transmit_go_bit
// - mid-frame stop sends 7F, then fill
// - between-frame stop keeps sending idle fill
// - stop transmit never advances tx_bd_pointer
// - setting transmit_go_bit starts or resumes transmit
// - stop receive halts channel, keeps receive parameters
// - no start commands; general_mode_word starts
// - write queue item, set valid, bump pointer
// - pointer reloads from base at wrap item
// - only unmasked exceptions queued; flags updated after
// - interrupt only unmasked; flag new queue items
// - underrun: sixteen ones per channel (two all-ones slots), flag, interrupt
// - underrun: stop fetching, fill until reinitialised
// - overrun: mark receivers stopped, flag, stop writes
// - flags cleared by writing one only
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cmd_exception_unit #(
  parameter int NCH = 32, // logical channels
  parameter int CW = 5 // channel index width
) (
  input wire logic CLK, // system clock, 25 MHz
  input wire logic RST_N, // synchronous reset, low active
  input wire logic [3:0] ADDR, // register index
  input wire logic [31:0] WDATA, // register write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [31:0] RDATA, // read data, cycle after RD
  input wire logic EXC_VALID, // channel exception request
  input wire logic [CW-1:0] EXC_CHAN, // channel raising it
  input wire logic [7:0] EXC_CODE, // exception description
  output logic EXC_READY, // queue writer can take a request
  output logic MEM_RD, // queue item read
  output logic MEM_WR, // queue item write
  output logic [15:0] MEM_ADDR, // queue item address
  output cmdexc_pkg::qitem_type MEM_WDATA, // item written
  input wire cmdexc_pkg::qitem_type MEM_RDATA, // item read, cycle after MEM_RD
  input wire logic SLOT_STB, // one transmit time slot is due
  input wire logic [CW-1:0] SLOT_CHAN, // channel owning that slot
  input wire logic [7:0] SLOT_DATA, // buffer byte for that channel
  input wire logic [NCH-1:0] TX_IN_FRAME, // channel is inside a frame
  output logic [7:0] TX_BYTE, // byte sent in the slot
  output logic TX_VLD, // TX_BYTE is new
  output logic TX_FETCH, // buffer byte consumed, pointer may advance
  output logic [NCH-1:0] RX_CHAN_EN, // receiver may write buffers
  input wire logic GUN_EV, // global transmit underrun pulse
  input wire logic GOV_EV, // global receive overrun pulse
  output logic IRQ // host interrupt, high active
);

  // register file
  logic [15:0] cmd_r, cmd_nxt; // last command word, pending bit live
  logic [cmdexc_pkg::FLG_W-1:0] flags_r, flags_nxt; // global_flag_word
  logic [cmdexc_pkg::FLG_W-1:0] fmask_r, fmask_nxt; // global_flag_mask
  logic [7:0] chmask_r, chmask_nxt; // channel_irq_mask
  logic [15:0] qbase_r, qbase_nxt; // irq_queue_base
  logic [15:0] qptr_r, qptr_nxt; // irq_queue_write_ptr
  logic [1:0] gmode_r, gmode_nxt; // general_mode_word
  logic [CW-1:0] chsel_r, chsel_nxt; // selected channel
  logic [31:0] rdata_r, rdata_nxt; // read data
  // per-channel state, flip-flops addressed by channel index
  cmdexc_pkg::chmode_type chm_r [NCH], chm_nxt [NCH]; // channel_mode_word
  logic [1:0] abt_r [NCH], abt_nxt [NCH]; // abort bytes still owed
  logic [NCH-1:0] hold_r, hold_nxt; // underrun hold, no fetching
  logic [NCH-1:0] rxstop_r, rxstop_nxt; // rx_internal_state stopped bit
  logic [NCH-1:0] rxen_r, rxen_nxt; // receive enables out
  // transmit slot outputs
  logic [7:0] txb_r, txb_nxt;
  logic txv_r, txv_nxt;
  logic txf_r, txf_nxt;
  // queue writer
  cmdexc_pkg::qstate_type qs_r, qs_nxt;
  cmdexc_pkg::qitem_type item_r, item_nxt; // item being posted
  logic memrd_r, memrd_nxt;
  logic memwr_r, memwr_nxt;
  logic [15:0] maddr_r, maddr_nxt;
  logic rdy_r, rdy_nxt;
  logic irq_r, irq_nxt;

  // strobe decode helper, used by every register
  function automatic logic hit(input logic stb, input logic [3:0] a, input logic [3:0] idx);
    hit = stb && (a == idx);
  endfunction

  // fill byte of a channel, flags or idles per its mode
  function automatic logic [7:0] fill(input cmdexc_pkg::chmode_type m);
    fill = m.idle_sel ? cmdexc_pkg::BYTE_FLAG : cmdexc_pkg::BYTE_IDLE;
  endfunction

  // command fields straight from the write data
  logic cmd_go; // a live command is being written
  logic [2:0] cmd_op;
  logic [CW-1:0] cmd_ch;
  assign cmd_go = hit(WR, ADDR, cmdexc_pkg::REG_CMD) && WDATA[cmdexc_pkg::CMD_PEND_BIT]
                  && !WDATA[cmdexc_pkg::CMD_RST_BIT];
  assign cmd_op = WDATA[cmdexc_pkg::CMD_OP_LSB +: 3];
  assign cmd_ch = WDATA[cmdexc_pkg::CMD_CH_LSB +: CW];

  // queue writer accepts a request only when idle
  logic exc_take;
  assign exc_take = EXC_VALID && rdy_r && (qs_r == cmdexc_pkg::Q_IDLE);

  // next state of registers, channels and transmit slot
  always_comb begin
    cmdexc_pkg::chmode_type wm;
    logic [cmdexc_pkg::FLG_W-1:0] clr;
    logic [cmdexc_pkg::FLG_W-1:0] set;
    wm = cmdexc_pkg::chmode_type'(WDATA[2:0]);
    clr = '0;
    set = '0;
    cmd_nxt = cmd_r;
    fmask_nxt = fmask_r;
    chmask_nxt = chmask_r;
    qbase_nxt = qbase_r;
    gmode_nxt = gmode_r;
    chsel_nxt = chsel_r;
    hold_nxt = hold_r;
    rxstop_nxt = rxstop_r;
    txb_nxt = txb_r;
    txv_nxt = 1'b0;
    txf_nxt = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      chm_nxt[i] = chm_r[i];
      abt_nxt[i] = abt_r[i];
    end
    // pending bit reads set only until the command has been carried out
    cmd_nxt[cmdexc_pkg::CMD_PEND_BIT] = 1'b0;
    if (hit(WR, ADDR, cmdexc_pkg::REG_CMD)) begin
      cmd_nxt = WDATA[15:0];
      cmd_nxt[cmdexc_pkg::CMD_PEND_BIT] = 1'b0; // done in the write cycle
    end
    if (hit(WR, ADDR, cmdexc_pkg::REG_FMASK)) fmask_nxt = WDATA[cmdexc_pkg::FLG_W-1:0];
    if (hit(WR, ADDR, cmdexc_pkg::REG_CHMASK)) chmask_nxt = WDATA[7:0];
    if (hit(WR, ADDR, cmdexc_pkg::REG_QBASE)) qbase_nxt = WDATA[15:0];
    if (hit(WR, ADDR, cmdexc_pkg::REG_GMODE)) gmode_nxt = WDATA[1:0];
    if (hit(WR, ADDR, cmdexc_pkg::REG_CHSEL)) chsel_nxt = WDATA[CW-1:0];
    if (hit(WR, ADDR, cmdexc_pkg::REG_FLAGS)) clr = WDATA[cmdexc_pkg::FLG_W-1:0];
    // channel mode write; a go bit of one also ends the underrun hold
    if (hit(WR, ADDR, cmdexc_pkg::REG_CHMODE)) begin
      chm_nxt[chsel_r] = wm;
      if (wm.go) hold_nxt[chsel_r] = 1'b0;
    end
    // restoring rx_internal_state with the stopped bit clear restarts reception
    if (hit(WR, ADDR, cmdexc_pkg::REG_RXST)) rxstop_nxt[chsel_r] = WDATA[cmdexc_pkg::RXST_STOP_BIT];
    // transmit slot: owed abort bytes first, then data, else fill
    if (SLOT_STB) begin
      txv_nxt = 1'b1;
      case (abt_r[SLOT_CHAN])
        cmdexc_pkg::ABT_7F: begin
          txb_nxt = cmdexc_pkg::BYTE_ABORT;
          abt_nxt[SLOT_CHAN] = cmdexc_pkg::ABT_NONE;
        end
        cmdexc_pkg::ABT_ONES: begin
          txb_nxt = cmdexc_pkg::BYTE_IDLE;
          abt_nxt[SLOT_CHAN] = cmdexc_pkg::ABT_ONES_LAST;
        end
        cmdexc_pkg::ABT_ONES_LAST: begin
          txb_nxt = cmdexc_pkg::BYTE_IDLE;
          abt_nxt[SLOT_CHAN] = cmdexc_pkg::ABT_NONE;
        end
        default: begin
          // fetch only when running; a stopped channel leaves its pointer alone
          if (gmode_r[cmdexc_pkg::GM_TXEN] && chm_r[SLOT_CHAN].go && chm_r[SLOT_CHAN].ena
              && !hold_r[SLOT_CHAN]) begin
            txb_nxt = SLOT_DATA;
            txf_nxt = 1'b1;
          end else begin
            txb_nxt = fill(chm_r[SLOT_CHAN]);
          end
        end
      endcase
    end
    // commands act on the named channel only
    if (cmd_go) begin
      case (cmd_op)
        cmdexc_pkg::OP_STOP_TX: begin
          chm_nxt[cmd_ch].go = 1'b0;
          if (TX_IN_FRAME[cmd_ch]) abt_nxt[cmd_ch] = cmdexc_pkg::ABT_7F;
        end
        cmdexc_pkg::OP_STOP_RX: rxstop_nxt[cmd_ch] = 1'b1;
        default: ; // no start commands exist, other codes do nothing
      endcase
    end
    // global underrun: all-ones abort on every channel, then hold
    if (GUN_EV) begin
      set[cmdexc_pkg::FLG_UND] = 1'b1;
      hold_nxt = '1;
      for (int i = 0; i < NCH; i++) abt_nxt[i] = cmdexc_pkg::ABT_ONES;
    end
    // global overrun: every receiver marked stopped
    if (GOV_EV) begin
      set[cmdexc_pkg::FLG_OVR] = 1'b1;
      rxstop_nxt = '1;
    end
    // queue writer events
    if (qs_r == cmdexc_pkg::Q_FLAG) set[cmdexc_pkg::FLG_QNEW] = 1'b1;
    if (qs_r == cmdexc_pkg::Q_CHECK && MEM_RDATA.valid) set[cmdexc_pkg::FLG_QOVF] = 1'b1;
    // a set in the same cycle as its clear wins
    flags_nxt = (flags_r & ~clr) | set;
    rxen_nxt = gmode_r[cmdexc_pkg::GM_RXEN] ? ~rxstop_r : '0;
    irq_nxt = |(flags_r & fmask_r);
  end

  // next state of the interrupt queue writer
  always_comb begin
    qs_nxt = qs_r;
    item_nxt = item_r;
    memrd_nxt = 1'b0;
    memwr_nxt = 1'b0;
    maddr_nxt = maddr_r;
    qptr_nxt = qptr_r;
    if (hit(WR, ADDR, cmdexc_pkg::REG_QPTR)) qptr_nxt = WDATA[15:0];
    case (qs_r)
      cmdexc_pkg::Q_IDLE: begin
        // masked exceptions are dropped without touching memory
        if (exc_take && ((EXC_CODE & chmask_r) != 8'h00)) begin
          item_nxt.valid = 1'b1;
          item_nxt.wrap = 1'b0;
          item_nxt.chan = 6'(EXC_CHAN);
          item_nxt.code = EXC_CODE & chmask_r;
          memrd_nxt = 1'b1; // fetch item for its wrap and valid bits
          maddr_nxt = qptr_r;
          qs_nxt = cmdexc_pkg::Q_READ;
        end
      end
      cmdexc_pkg::Q_READ: qs_nxt = cmdexc_pkg::Q_CHECK;
      cmdexc_pkg::Q_CHECK: begin
        // an unserved item is never overwritten; that exception is lost
        if (MEM_RDATA.valid) begin
          qs_nxt = cmdexc_pkg::Q_IDLE;
        end else begin
          item_nxt.wrap = MEM_RDATA.wrap; // keep host wrap mark
          memwr_nxt = 1'b1;
          qptr_nxt = MEM_RDATA.wrap ? qbase_r : qptr_r + 16'h0001;
          qs_nxt = cmdexc_pkg::Q_FLAG;
        end
      end
      cmdexc_pkg::Q_FLAG: qs_nxt = cmdexc_pkg::Q_IDLE;
      default: qs_nxt = cmdexc_pkg::Q_IDLE;
    endcase
    rdy_nxt = (qs_nxt == cmdexc_pkg::Q_IDLE);
  end

  // read mux, data stand only in the cycle after the strobe
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (RD) begin
      case (ADDR)
        cmdexc_pkg::REG_CMD: rdata_nxt[15:0] = cmd_r;
        cmdexc_pkg::REG_FLAGS: rdata_nxt[cmdexc_pkg::FLG_W-1:0] = flags_r;
        cmdexc_pkg::REG_FMASK: rdata_nxt[cmdexc_pkg::FLG_W-1:0] = fmask_r;
        cmdexc_pkg::REG_CHMASK: rdata_nxt[7:0] = chmask_r;
        cmdexc_pkg::REG_QBASE: rdata_nxt[15:0] = qbase_r;
        cmdexc_pkg::REG_QPTR: rdata_nxt[15:0] = qptr_r;
        cmdexc_pkg::REG_GMODE: rdata_nxt[1:0] = gmode_r;
        cmdexc_pkg::REG_CHSEL: rdata_nxt[CW-1:0] = chsel_r;
        cmdexc_pkg::REG_CHMODE: rdata_nxt[2:0] = chm_r[chsel_r];
        cmdexc_pkg::REG_RXST: rdata_nxt[cmdexc_pkg::RXST_STOP_BIT] = rxstop_r[chsel_r];
        default: rdata_nxt = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // all state registers; channels reset disabled with stopped bits clear
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cmd_r <= 16'h0000;
      flags_r <= '0;
      fmask_r <= cmdexc_pkg::FMASK_RST;
      chmask_r <= cmdexc_pkg::CHMASK_RST;
      qbase_r <= cmdexc_pkg::QADDR_RST;
      qptr_r <= cmdexc_pkg::QADDR_RST;
      gmode_r <= cmdexc_pkg::GMODE_RST;
      chsel_r <= '0;
      rdata_r <= 32'h0000_0000;
      for (int i = 0; i < NCH; i++) begin
        chm_r[i] <= '0;
        abt_r[i] <= cmdexc_pkg::ABT_NONE;
      end
      hold_r <= '0;
      rxstop_r <= '0;
      rxen_r <= '0;
      txb_r <= 8'h00;
      txv_r <= 1'b0;
      txf_r <= 1'b0;
      qs_r <= cmdexc_pkg::Q_IDLE;
      item_r <= '0;
      memrd_r <= 1'b0;
      memwr_r <= 1'b0;
      maddr_r <= cmdexc_pkg::QADDR_RST;
      rdy_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      cmd_r <= cmd_nxt;
      flags_r <= flags_nxt;
      fmask_r <= fmask_nxt;
      chmask_r <= chmask_nxt;
      qbase_r <= qbase_nxt;
      qptr_r <= qptr_nxt;
      gmode_r <= gmode_nxt;
      chsel_r <= chsel_nxt;
      rdata_r <= rdata_nxt;
      for (int i = 0; i < NCH; i++) begin
        chm_r[i] <= chm_nxt[i];
        abt_r[i] <= abt_nxt[i];
      end
      hold_r <= hold_nxt;
      rxstop_r <= rxstop_nxt;
      rxen_r <= rxen_nxt;
      txb_r <= txb_nxt;
      txv_r <= txv_nxt;
      txf_r <= txf_nxt;
      qs_r <= qs_nxt;
      item_r <= item_nxt;
      memrd_r <= memrd_nxt;
      memwr_r <= memwr_nxt;
      maddr_r <= maddr_nxt;
      rdy_r <= rdy_nxt;
      irq_r <= irq_nxt;
    end
  end

  // outputs straight from flip-flops
  assign RDATA = rdata_r;
  assign EXC_READY = rdy_r;
  assign MEM_RD = memrd_r;
  assign MEM_WR = memwr_r;
  assign MEM_ADDR = maddr_r;
  assign MEM_WDATA = item_r;
  assign TX_BYTE = txb_r;
  assign TX_VLD = txv_r;
  assign TX_FETCH = txf_r;
  assign RX_CHAN_EN = rxen_r;
  assign IRQ = irq_r;

endmodule // cmd_exception_unit
`default_nettype wire
